// ===== inc/sncs_pkg.sv
// constants, types and helpers for the serial node configuration selector
package sncs_pkg;
   ///////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned DEB_TIME_US = 10_000;
   localparam int unsigned DEB_CYCLES  = ((CLK_HZ / 1_000_000) * DEB_TIME_US);
   localparam int unsigned RATE1_BPS   = 9_600;
   localparam int unsigned RATE2_BPS   = 38_400;
   localparam int unsigned RATE3_BPS   = 115_200;
   localparam int unsigned RATE1_DIV   = CLK_HZ / RATE1_BPS;
   localparam int unsigned RATE2_DIV   = CLK_HZ / RATE2_BPS;
   localparam int unsigned RATE3_DIV   = CLK_HZ / RATE3_BPS;
   localparam int unsigned DIV_W       = 12;

   ///////////////////////////////////////////////////////////////////////////
   // field widths and positions
   localparam int unsigned ADDR_W    = 6;
   localparam int unsigned RATE_W    = 2;
   localparam int unsigned SW_W      = 8;
   localparam int unsigned ADDR_LSB  = 0;
   localparam int unsigned RATE_LSB  = 8;
   localparam int unsigned RAW_LSB   = 16;
   localparam int unsigned VALID_BIT = 24;
   localparam int unsigned MD_BIT    = 25;
   localparam int unsigned ENC_A_BIT = 0;
   localparam int unsigned ENC_B_BIT = 1;
   localparam int unsigned ENC_I_BIT = 2;

   ///////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] REG_NV_MD  = 8'h00;
   localparam logic [7:0] REG_P2P    = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ENC    = 8'h0C;

   ///////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [5:0]  NV_ADDR_RST  = 6'h01;
   localparam logic [1:0]  NV_RATE_RST  = 2'h1;
   localparam logic [5:0]  P2P_ADDR_RST = 6'h01;
   localparam logic [1:0]  P2P_RATE_RST = 2'h1;
   localparam logic [2:0]  ENC_RST      = 3'h0;
   localparam logic [1:0]  RATE_NV      = 2'h0;
   localparam logic [1:0]  RATE_FALLBK  = 2'h1;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   ///////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic [1:0] rate;
      logic [5:0] addr;
   } sncs_cfg_t;

   typedef enum logic [0:0] {
      SNCS_WAIT = 1'b0,
      SNCS_HOLD = 1'b1
   } sncs_state_t;

   ///////////////////////////////////////////////////////////////////////////
   // bit-rate code to clock divider
   function automatic logic [11:0] sncs_rate_div(input logic [1:0] code);
      case (code)
         2'h2:    sncs_rate_div = 12'(RATE2_DIV);
         2'h3:    sncs_rate_div = 12'(RATE3_DIV);
         default: sncs_rate_div = 12'(RATE1_DIV);
      endcase
   endfunction

   // substitute stored value when the switch field is zero, or rate code 1 when the stored rate is also zero
   function automatic sncs_cfg_t sncs_resolve(input sncs_cfg_t sw, input sncs_cfg_t nv);
      sncs_cfg_t r;
      r.addr = (sw.addr != 6'h00) ? sw.addr : nv.addr;
      r.rate = (sw.rate != RATE_NV) ? sw.rate : ((nv.rate != RATE_NV) ? nv.rate : RATE_FALLBK);
      return r;
   endfunction
endpackage

// ===== verilog/sncs_debounce.sv
// synchroniser and stability filter for the configuration switches
`timescale 1ns/1ps
module sncs_debounce #(
   parameter int unsigned W   = 8,
   parameter int unsigned CNT = 250_000
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_b,
   // raw pins
   input  wire logic [W-1:0] raw,
   // filtered result
   output logic      [W-1:0] stable,
   output logic              settled
);
   localparam int unsigned CW = $clog2(CNT + 1);
   localparam logic [CW-1:0] LAST = CW'(CNT - 1);

   logic [W-1:0]  meta_q;
   logic [W-1:0]  sync_q;
   logic [W-1:0]  prev_q;
   logic [CW-1:0] cnt_q;
   logic [W-1:0]  stable_q;
   logic          settled_q;

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchroniser
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stability counter
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         prev_q    <= '0;
         cnt_q     <= '0;
         stable_q  <= '0;
         settled_q <= 1'b0;
      end else if (sync_q != prev_q) begin
         prev_q <= sync_q;
         cnt_q  <= '0;
      end else if (cnt_q == LAST) begin
         stable_q  <= prev_q;
         settled_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   assign stable  = stable_q;
   assign settled = settled_q;
endmodule

// ===== verilog/serial_node_config_select.sv
// serial link node address and bit-rate selector with ahb-lite registers
//
// Function
// - switches one to six form the multidrop node address, switch one as bit 0, closed reads 1.
// - switches seven and eight form the bit-rate code, switch seven as bit 0, closed reads 1.
// - a zero address or a zero rate code from the switches is replaced by the stored value, and a zero stored rate by code 1.
// - rate code 1 is 9.6 kbps, 2 is 38.4 kbps, 3 is 115.2 kbps and 0 means the stored rate.
// - the point-to-point link configuration never depends on the switches.
// - emulated encoder channels a, b and index leave as complementary pairs.
// - a grounded interface select picks the multidrop link, otherwise point-to-point.
`timescale 1ns/1ps
module serial_node_config_select #(
   parameter int unsigned DEB_CYCLES = sncs_pkg::DEB_CYCLES
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // board pins
   input  wire logic [7:0]  cfgSwitch,
   input  wire logic        ifSelect,
   // resolved link configuration
   output logic [5:0]       mdNodeAddr,
   output logic [1:0]       mdRateCode,
   output logic [5:0]       p2pNodeAddr,
   output logic [1:0]       p2pRateCode,
   output logic             linkMultidrop,
   output logic             cfgValid,
   output logic             bitTick,
   // emulated encoder pairs
   output logic             emu_quad_a_pos,
   output logic             emu_quad_a_neg,
   output logic             emu_quad_b_pos,
   output logic             emu_quad_b_neg,
   output logic             emu_index_pos,
   output logic             emu_index_neg
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [7:0]            swStable;
   logic                  swSettled;
   sncs_pkg::sncs_state_t state_q;
   sncs_pkg::sncs_cfg_t   swCfg_q;
   sncs_pkg::sncs_cfg_t   nvCfg_q;
   sncs_pkg::sncs_cfg_t   p2pCfg_q;
   sncs_pkg::sncs_cfg_t   mdCfg_q;
   sncs_pkg::sncs_cfg_t   mdCfg_d;
   logic [2:0]            enc_q;
   logic                  selMeta_q;
   logic                  selSync_q;
   logic                  mdMode_q;
   logic                  valid_q;
   logic                  dpWrite_q;
   logic [7:0]            dpAddr_q;
   logic [31:0]           rdata_q;
   logic [31:0]           rdata_d;
   logic                  ready_q;
   logic                  resp_q;
   logic [11:0]           divCnt_q;
   logic [11:0]           divLimit;
   logic                  tick_q;
   logic                  encAP_q;
   logic                  encAN_q;
   logic                  encBP_q;
   logic                  encBN_q;
   logic                  encIP_q;
   logic                  encIN_q;
   logic                  addrPhase;

   ////////////////////////////////////////////////////////////////////////////
   // switch filter
   sncs_debounce #(
      .W   (sncs_pkg::SW_W),
      .CNT (DEB_CYCLES)
   ) u_deb (
      .clock   (clock),
      .rst_b   (rst_b),
      .raw     (cfgSwitch),
      .stable  (swStable),
      .settled (swSettled)
   );

   ////////////////////////////////////////////////////////////////////////////
   // one-shot capture after reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_q      <= sncs_pkg::SNCS_WAIT;
         swCfg_q      <= '0;
      end else begin
         case (state_q)
            sncs_pkg::SNCS_WAIT: begin
               if (swSettled) begin
                  swCfg_q.addr <= swStable[5:0];
                  swCfg_q.rate <= swStable[7:6];
                  state_q      <= sncs_pkg::SNCS_HOLD;
               end
            end
            sncs_pkg::SNCS_HOLD: begin
               state_q <= sncs_pkg::SNCS_HOLD;
            end
            default: begin
               state_q <= sncs_pkg::SNCS_WAIT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stored value substitution
   always_comb begin
      mdCfg_d = sncs_pkg::sncs_resolve(swCfg_q, nvCfg_q);
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         mdCfg_q <= '0;
         valid_q <= 1'b0;
      end else begin
         mdCfg_q <= mdCfg_d;
         valid_q <= (state_q == sncs_pkg::SNCS_HOLD);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interface select
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         selMeta_q <= 1'b1;
         selSync_q <= 1'b1;
         mdMode_q  <= 1'b0;
      end else begin
         selMeta_q <= ifSelect;
         selSync_q <= selMeta_q;
         mdMode_q  <= ~selSync_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit-rate divider for the active link
   always_comb begin
      if (mdMode_q) begin
         divLimit = sncs_pkg::sncs_rate_div(mdCfg_q.rate);
      end else begin
         divLimit = sncs_pkg::sncs_rate_div(p2pCfg_q.rate);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         divCnt_q <= '0;
         tick_q   <= 1'b0;
      end else if (mdMode_q && !valid_q) begin
         divCnt_q <= '0;
         tick_q   <= 1'b0;
      end else if (divCnt_q >= divLimit - 12'h001) begin
         divCnt_q <= '0;
         tick_q   <= 1'b1;
      end else begin
         divCnt_q <= divCnt_q + 12'h001;
         tick_q   <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite address phase
   assign addrPhase = hsel && htrans[1] && hready;

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         dpWrite_q <= 1'b0;
         dpAddr_q  <= '0;
         ready_q   <= 1'b0;
         resp_q    <= 1'b0;
      end else begin
         dpWrite_q <= addrPhase && hwrite;
         dpAddr_q  <= haddr[7:0];
         ready_q   <= 1'b1;
         resp_q    <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux, registered into the data phase
   always_comb begin
      rdata_d = sncs_pkg::ZERO_WORD;
      case (haddr[7:0])
         sncs_pkg::REG_NV_MD: begin
            rdata_d[sncs_pkg::ADDR_LSB +: 6] = nvCfg_q.addr;
            rdata_d[sncs_pkg::RATE_LSB +: 2] = nvCfg_q.rate;
         end
         sncs_pkg::REG_P2P: begin
            rdata_d[sncs_pkg::ADDR_LSB +: 6] = p2pCfg_q.addr;
            rdata_d[sncs_pkg::RATE_LSB +: 2] = p2pCfg_q.rate;
         end
         sncs_pkg::REG_STATUS: begin
            rdata_d[sncs_pkg::ADDR_LSB +: 6] = mdCfg_q.addr;
            rdata_d[sncs_pkg::RATE_LSB +: 2] = mdCfg_q.rate;
            rdata_d[sncs_pkg::RAW_LSB +: 8]  = {swCfg_q.rate, swCfg_q.addr};
            rdata_d[sncs_pkg::VALID_BIT]     = valid_q;
            rdata_d[sncs_pkg::MD_BIT]        = mdMode_q;
         end
         sncs_pkg::REG_ENC: begin
            rdata_d[2:0] = enc_q;
         end
         default: begin
            rdata_d = sncs_pkg::ZERO_WORD;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rdata_q <= sncs_pkg::ZERO_WORD;
      end else if (addrPhase && !hwrite) begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes in the data phase
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         nvCfg_q.addr  <= sncs_pkg::NV_ADDR_RST;
         nvCfg_q.rate  <= sncs_pkg::NV_RATE_RST;
         p2pCfg_q.addr <= sncs_pkg::P2P_ADDR_RST;
         p2pCfg_q.rate <= sncs_pkg::P2P_RATE_RST;
         enc_q         <= sncs_pkg::ENC_RST;
      end else if (dpWrite_q) begin
         case (dpAddr_q)
            sncs_pkg::REG_NV_MD: begin
               nvCfg_q.addr <= hwdata[sncs_pkg::ADDR_LSB +: 6];
               nvCfg_q.rate <= hwdata[sncs_pkg::RATE_LSB +: 2];
            end
            sncs_pkg::REG_P2P: begin
               p2pCfg_q.addr <= hwdata[sncs_pkg::ADDR_LSB +: 6];
               p2pCfg_q.rate <= hwdata[sncs_pkg::RATE_LSB +: 2];
            end
            sncs_pkg::REG_ENC: begin
               enc_q <= hwdata[2:0];
            end
            default: begin
               enc_q <= enc_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // complementary encoder drivers
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         encAP_q <= 1'b0;
         encAN_q <= 1'b1;
         encBP_q <= 1'b0;
         encBN_q <= 1'b1;
         encIP_q <= 1'b0;
         encIN_q <= 1'b1;
      end else begin
         encAP_q <= enc_q[sncs_pkg::ENC_A_BIT];
         encAN_q <= ~enc_q[sncs_pkg::ENC_A_BIT];
         encBP_q <= enc_q[sncs_pkg::ENC_B_BIT];
         encBN_q <= ~enc_q[sncs_pkg::ENC_B_BIT];
         encIP_q <= enc_q[sncs_pkg::ENC_I_BIT];
         encIN_q <= ~enc_q[sncs_pkg::ENC_I_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign hrdata         = rdata_q;
   assign hreadyout      = ready_q;
   assign hresp          = resp_q;
   assign mdNodeAddr     = mdCfg_q.addr;
   assign mdRateCode     = mdCfg_q.rate;
   assign p2pNodeAddr    = p2pCfg_q.addr;
   assign p2pRateCode    = p2pCfg_q.rate;
   assign linkMultidrop  = mdMode_q;
   assign cfgValid       = valid_q;
   assign bitTick        = tick_q;
   assign emu_quad_a_pos = encAP_q;
   assign emu_quad_a_neg = encAN_q;
   assign emu_quad_b_pos = encBP_q;
   assign emu_quad_b_neg = encBN_q;
   assign emu_index_pos  = encIP_q;
   assign emu_index_neg  = encIN_q;
endmodule

// ===== tb/sncs_chk.sv
// assertions on the ports of the node configuration selector
`timescale 1ns/1ps
module sncs_chk #(
   parameter int unsigned DEB_CYCLES = 8
) (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_b,
   // bus address phase
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   // pins and resolved configuration
   input wire logic [7:0]  cfgSwitch,
   input wire logic        ifSelect,
   input wire logic [5:0]  mdNodeAddr,
   input wire logic [1:0]  mdRateCode,
   input wire logic [5:0]  p2pNodeAddr,
   input wire logic [1:0]  p2pRateCode,
   input wire logic        linkMultidrop,
   input wire logic        cfgValid,
   input wire logic        bitTick,
   // encoder pairs
   input wire logic        emu_quad_a_pos,
   input wire logic        emu_quad_a_neg,
   input wire logic        emu_quad_b_pos,
   input wire logic        emu_quad_b_neg,
   input wire logic        emu_index_pos,
   input wire logic        emu_index_neg
);
   logic [7:0] swCap_q;
   logic       wrP2p_q;
   ////////////////////////////////////////////////////////////////////////////
   // switch value before capture, and point-to-point writes
   always_ff @(posedge clock) begin
      if (!cfgValid) begin
         swCap_q <= cfgSwitch;
      end
   end
   always_ff @(posedge clock) begin
      wrP2p_q <= hsel && htrans[1] && hready && hwrite && (haddr[7:0] == sncs_pkg::REG_P2P);
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   property p_encPair;
      {emu_quad_a_neg, emu_quad_b_neg, emu_index_neg} == ~{emu_quad_a_pos, emu_quad_b_pos, emu_index_pos};
   endproperty
   a_encPair: assert property (p_encPair) else $error("encoder pair not complementary");
   property p_p2pBus;
      !$stable({p2pNodeAddr, p2pRateCode}) |-> $past(wrP2p_q) || $past(wrP2p_q, 2);
   endproperty
   a_p2pBus: assert property (p_p2pBus) else $error("p2p config moved without a write");
   property p_mdSel;
      !ifSelect [*4] |-> linkMultidrop;
   endproperty
   a_mdSel: assert property (p_mdSel) else $error("grounded select not multidrop");
   property p_p2pSel;
      ifSelect [*4] |-> !linkMultidrop;
   endproperty
   a_p2pSel: assert property (p_p2pSel) else $error("high select not point-to-point");
   property p_validHold;
      cfgValid |=> cfgValid;
   endproperty
   a_validHold: assert property (p_validHold) else $error("capture flag dropped");
   property p_swAddr;
      $past(cfgValid, 2) && cfgValid && (swCap_q[5:0] != 6'h00) |-> mdNodeAddr == swCap_q[5:0];
   endproperty
   a_swAddr: assert property (p_swAddr) else $error("address differs from switches");
   property p_swRate;
      $past(cfgValid, 2) && cfgValid && (swCap_q[7:6] != 2'h0) |-> mdRateCode == swCap_q[7:6];
   endproperty
   a_swRate: assert property (p_swRate) else $error("rate differs from switches");
   property p_tickIdle;
      !cfgValid && linkMultidrop && $past(linkMultidrop) |-> !bitTick;
   endproperty
   a_tickIdle: assert property (p_tickIdle) else $error("tick before capture");
   property p_tickFast;
      bitTick && linkMultidrop && (mdRateCode == 2'h3) |=> !bitTick [*8] ##209 (bitTick || !linkMultidrop);
   endproperty
   a_tickFast: assert property (p_tickFast) else $error("fast rate period wrong");
endmodule

bind serial_node_config_select sncs_chk #(.DEB_CYCLES(DEB_CYCLES)) i_chk (
   .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .cfgSwitch(cfgSwitch), .ifSelect(ifSelect), .mdNodeAddr(mdNodeAddr),
   .mdRateCode(mdRateCode), .p2pNodeAddr(p2pNodeAddr), .p2pRateCode(p2pRateCode),
   .linkMultidrop(linkMultidrop), .cfgValid(cfgValid), .bitTick(bitTick),
   .emu_quad_a_pos(emu_quad_a_pos), .emu_quad_a_neg(emu_quad_a_neg), .emu_quad_b_pos(emu_quad_b_pos),
   .emu_quad_b_neg(emu_quad_b_neg), .emu_index_pos(emu_index_pos), .emu_index_neg(emu_index_neg)
);

// ===== tb/sncs_switch_bank.sv
// switch bank and interface select strap in front of the selector
`timescale 1ns/1ps
module sncs_switch_bank (
   // clock
   input  wire logic       clock,
   // wanted settings
   input  wire logic [7:0] setting,
   input  wire logic       chatter,
   input  wire logic       selLevel,
   // board pins
   output logic      [7:0] cfgSwitch,
   output logic            ifSelect
);
   logic flip_q = 1'b0;
   always_ff @(posedge clock) begin
      flip_q <= ~flip_q;
   end
   // contact bounce flips every switch each cycle; closed reads 1
   assign cfgSwitch = chatter ? (setting ^ {8{flip_q}}) : setting;
   assign ifSelect  = selLevel;
endmodule

// ===== tb/testbench.sv
// self-checking bench for the node configuration selector
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [7:0]  sw;
      logic [31:0] nv;
      logic [5:0]  addr;
      logic [1:0]  rate;
   } sncs_row_t;
   localparam int unsigned DEB = 8;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [7:0]  swSetting = 8'h00;
   logic        chatter = 1'b0;
   logic        selLevel = 1'b0;
   logic [31:0] hrdata, rd;
   logic        hreadyout, hresp, ifSelect, linkMultidrop, cfgValid, bitTick;
   logic [7:0]  cfgSwitch;
   logic [5:0]  mdNodeAddr, p2pNodeAddr;
   logic [1:0]  mdRateCode, p2pRateCode;
   logic [2:0]  encPos, encNeg;
   int          gap;
   int          errors = 0;
   int          total_checks = 0;
   sncs_row_t   rows [7] = '{'{8'h45, 32'h0000_0101, 6'h05, 2'h1}, '{8'h8A, 32'h0000_0101, 6'h0A, 2'h2},
      '{8'hFF, 32'h0000_0101, 6'h3F, 2'h3}, '{8'h00, 32'h0000_032A, 6'h2A, 2'h3},
      '{8'hC0, 32'h0000_0211, 6'h11, 2'h3}, '{8'h07, 32'h0000_0209, 6'h07, 2'h2},
      '{8'h00, 32'h0000_0000, 6'h00, 2'h1}};

   always #20 clock = ~clock;
   sncs_switch_bank i_sw (.clock(clock), .setting(swSetting), .chatter(chatter), .selLevel(selLevel),
      .cfgSwitch(cfgSwitch), .ifSelect(ifSelect));
   serial_node_config_select #(.DEB_CYCLES(DEB)) i_dut (
      .clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cfgSwitch(cfgSwitch), .ifSelect(ifSelect), .mdNodeAddr(mdNodeAddr),
      .mdRateCode(mdRateCode), .p2pNodeAddr(p2pNodeAddr), .p2pRateCode(p2pRateCode),
      .linkMultidrop(linkMultidrop), .cfgValid(cfgValid), .bitTick(bitTick),
      .emu_quad_a_pos(encPos[0]), .emu_quad_a_neg(encNeg[0]), .emu_quad_b_pos(encPos[1]),
      .emu_quad_b_neg(encNeg[1]), .emu_index_pos(encPos[2]), .emu_index_neg(encNeg[2]));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask
   task automatic do_reset(input logic [7:0] sw, input logic chat);
      rst_b <= 1'b0;
      swSetting <= sw;
      chatter <= chat;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      repeat (5) @(posedge clock);
      chatter <= 1'b0;
   endtask
   task automatic wait_valid();
      do @(posedge clock); while (cfgValid !== 1'b1);
      repeat (2) @(posedge clock);
   endtask
   task automatic tick_gap(output int g);
      g = 0;
      do @(posedge clock); while (bitTick !== 1'b1);
      do begin
         @(posedge clock);
         g++;
      end while (bitTick !== 1'b1);
   endtask
   function automatic int divOf(input logic [1:0] r);
      return (r == 2'h2) ? sncs_pkg::RATE2_DIV : ((r == 2'h3) ? sncs_pkg::RATE3_DIV : sncs_pkg::RATE1_DIV);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #4_000_000;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge clock);
      check({24'h00_0000, p2pRateCode, p2pNodeAddr}, 32'h0000_0041);
      check({26'h000_0000, encNeg, encPos}, 32'h0000_0038);
      check({30'h0000_0000, cfgValid, linkMultidrop}, 32'h0000_0000);
      rst_b <= 1'b1;
      repeat (2) @(posedge clock);
      xfer(sncs_pkg::REG_NV_MD, 1'b0, 32'h0000_0000, rd);
      check(rd, 32'h0000_0101);
      check({24'h00_0000, mdRateCode, mdNodeAddr}, 32'h0000_0041);
      $display("reset done");
      foreach (rows[i]) begin
         do_reset(rows[i].sw, 1'b0);
         wait_valid();
         xfer(sncs_pkg::REG_NV_MD, 1'b1, rows[i].nv, rd);
         repeat (3) @(posedge clock);
         check({24'h00_0000, mdRateCode, mdNodeAddr}, {24'h00_0000, rows[i].rate, rows[i].addr});
         check({24'h00_0000, p2pRateCode, p2pNodeAddr}, 32'h0000_0041);
         xfer(sncs_pkg::REG_STATUS, 1'b0, 32'h0000_0000, rd);
         check(rd, {6'h00, 2'h3, rows[i].sw, 6'h00, rows[i].rate, 2'h0, rows[i].addr});
         tick_gap(gap);
         check(32'(gap), 32'(divOf(rows[i].rate)));
         $display("row %0d done", i);
      end
      do_reset(8'h4C, 1'b1);
      wait_valid();
      swSetting <= 8'hFF;
      repeat (20) @(posedge clock);
      xfer(sncs_pkg::REG_STATUS, 1'b0, 32'h0000_0000, rd);
      check(rd, 32'h034C_010C);
      $display("bounce and hold done");
      xfer(sncs_pkg::REG_P2P, 1'b1, 32'h0000_0305, rd);
      selLevel <= 1'b1;
      repeat (5) @(posedge clock);
      check({31'h0000_0000, linkMultidrop}, 32'h0000_0000);
      check({24'h00_0000, p2pRateCode, p2pNodeAddr}, 32'h0000_00C5);
      tick_gap(gap);
      check(32'(gap), 32'(sncs_pkg::RATE3_DIV));
      selLevel <= 1'b0;
      repeat (5) @(posedge clock);
      check({31'h0000_0000, linkMultidrop}, 32'h0000_0001);
      $display("link select done");
      for (int e = 0; e < 8; e++) begin
         xfer(sncs_pkg::REG_ENC, 1'b1, 32'(e), rd);
         xfer(sncs_pkg::REG_ENC, 1'b0, 32'h0000_0000, rd);
         check(rd, 32'(e));
         check({26'h000_0000, encNeg, encPos}, {26'h000_0000, ~3'(e), 3'(e)});
      end
      $display("encoder pairs done");
      xfer(8'h10, 1'b1, 32'hFFFF_FFFF, rd);
      xfer(8'h10, 1'b0, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
      $display("unmapped access done");
      print_verdict();
   end
endmodule
